// [hw/angle_linearizer.sv]
/*
 * angle linearizer: fifo, two-stage correction pipeline, wake tracker
 * and axi4-lite register slave.
 * assumes angle samples and low_power come from logic on clk.
 */
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "angle_lin_map.svh"

// ----------------------------------------
// fifo
// ----------------------------------------
module lin_fifo #(
   parameter int W = 16,
   parameter int D = 8
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         reset,
   // fill side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // drain side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(D);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       wp;
      logic [AW-1:0]       rp;
      logic [AW:0]         cnt;
      logic                rdy;
   } fifo_st_t;

   fifo_st_t st_ff;
   fifo_st_t nxt_st;
   logic     push;
   logic     pop;

   assign in_ready  = st_ff.rdy;
   assign out_valid = (st_ff.cnt != '0);
   assign out_data  = st_ff.mem[st_ff.rp];

   always_comb begin
      nxt_st = st_ff;
      push   = in_valid && st_ff.rdy;
      pop    = out_valid && out_ready;
      if (push) begin
         nxt_st.mem[st_ff.wp] = in_data;
         nxt_st.wp            = st_ff.wp + 1'b1;
      end
      if (pop) begin
         nxt_st.rp = st_ff.rp + 1'b1;
      end
      nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
      nxt_st.rdy = (nxt_st.cnt != (AW+1)'(D));
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st_ff     <= '0;
         st_ff.rdy <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end
endmodule // lin_fifo

// ----------------------------------------
// top
// ----------------------------------------
module angle_linearizer
   import angle_lin_pkg::*;
#(
   parameter int WAKE_WIN = `WAKE_WIN_CYC
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // raw angle stream
   input  wire logic        angle_valid,
   output logic             angle_ready,
   input  wire angle_t      angle_in,
   // corrected angle stream
   output logic             lin_valid,
   input  wire logic        lin_ready,
   output angle_t           lin_angle,
   // low-power tracking
   input  wire logic        low_power,
   output logic             awake,
   // axi4-lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);

   typedef struct packed {
      logic [`NUM_COEF-1:0][`COEF_W-1:0] coef;
      logic                 en;
      logic                 scale;
      logic [15:0]          thr;
      logic                 aw_got;
      logic                 w_got;
      logic [7:0]           awaddr;
      logic [31:0]          wdata;
      logic                 awready;
      logic                 wready;
      logic                 bvalid;
      logic [1:0]           bresp;
      logic                 arready;
      logic                 rvalid;
      logic [31:0]          rdata;
      logic [1:0]           rresp;
      logic                 s1_v;
      angle_t               s1_ang;
      logic [`FRAC_W-1:0]   s1_frac;
      coef_t                s1_c0;
      coef_t                s1_c1;
      logic                 out_v;
      angle_t               out_ang;
      logic [31:0]          win_cnt;
      angle_t               win_ang;
      angle_t               last_raw;
      logic                 awake;
   } lin_st_t;

   lin_st_t st_ff;
   lin_st_t nxt_st;

   logic   fifo_valid;
   angle_t fifo_data;
   logic   adv;
   logic   pop;
   angle_t delta;
   angle_t mag;

   // correction in angle lsb; one coefficient lsb is 2 or 4 angle lsb
   function automatic angle_t corr_of(coef_t c0, coef_t c1,
                                      logic [`FRAC_W-1:0] frac, logic sc);
      logic signed [24:0] acc;
      acc = ($signed({{13{c0[11]}}, c0}) <<< `FRAC_W)
          + ($signed({c1[11], c1}) - $signed({c0[11], c0}))
            * $signed({1'b0, frac});
      acc = acc >>> (`FRAC_W - 1 - 32'(sc));
      return acc[`ANG_W-1:0];
   endfunction

   function automatic logic is_coef(logic [7:0] a);
      return (a <= `COEF_LAST) && (a[1:0] == 2'b00);
   endfunction

   lin_fifo #(
      .W (`ANG_W),
      .D (`FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .reset     (reset),
      .in_valid  (angle_valid),
      .in_ready  (angle_ready),
      .in_data   (angle_in),
      .out_valid (fifo_valid),
      .out_ready (adv),
      .out_data  (fifo_data)
   );

   assign adv           = !st_ff.out_v || lin_ready;
   assign pop           = fifo_valid && adv;
   assign lin_valid     = st_ff.out_v;
   assign lin_angle     = st_ff.out_ang;
   assign awake         = st_ff.awake;
   assign s_axi_awready = st_ff.awready;
   assign s_axi_wready  = st_ff.wready;
   assign s_axi_bvalid  = st_ff.bvalid;
   assign s_axi_bresp   = st_ff.bresp;
   assign s_axi_arready = st_ff.arready;
   assign s_axi_rvalid  = st_ff.rvalid;
   assign s_axi_rdata   = st_ff.rdata;
   assign s_axi_rresp   = st_ff.rresp;
   assign delta         = st_ff.last_raw - st_ff.win_ang;
   assign mag           = delta[`ANG_W-1] ? -delta : delta;

   always_comb begin
      nxt_st = st_ff;
      // ----------------------------------------
      // correction pipeline
      // ----------------------------------------
      if (adv) begin
         nxt_st.s1_v  = fifo_valid;
         nxt_st.out_v = st_ff.s1_v;
         if (fifo_valid) begin
            nxt_st.s1_ang  = fifo_data;
            nxt_st.s1_frac = fifo_data[`FRAC_W-1:0];
            nxt_st.s1_c0   = st_ff.coef[fifo_data[`ANG_W-1 -: `SEG_W]];
            nxt_st.s1_c1   = st_ff.coef[fifo_data[`ANG_W-1 -: `SEG_W] + 1'b1];
         end
         if (st_ff.s1_v) begin
            if (st_ff.en) begin
               nxt_st.out_ang = st_ff.s1_ang
                  - corr_of(st_ff.s1_c0, st_ff.s1_c1, st_ff.s1_frac, st_ff.scale);
            end else begin
               nxt_st.out_ang = st_ff.s1_ang;
            end
         end
      end
      // ----------------------------------------
      // wake tracker on the raw angle
      // ----------------------------------------
      if (pop) begin
         nxt_st.last_raw = fifo_data;
      end
      if (st_ff.win_cnt >= 32'(WAKE_WIN - 1)) begin
         nxt_st.win_cnt = '0;
         nxt_st.win_ang = st_ff.last_raw;
         nxt_st.awake   = !low_power || (mag > st_ff.thr);
      end else begin
         nxt_st.win_cnt = st_ff.win_cnt + 32'd1;
      end
      // ----------------------------------------
      // axi write
      // ----------------------------------------
      if (s_axi_awvalid && st_ff.awready) begin
         nxt_st.aw_got  = 1'b1;
         nxt_st.awaddr  = s_axi_awaddr;
         nxt_st.awready = 1'b0;
      end
      if (s_axi_wvalid && st_ff.wready) begin
         nxt_st.w_got  = 1'b1;
         nxt_st.wdata  = s_axi_wdata;
         nxt_st.wready = 1'b0;
      end
      if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid) begin
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp  = RESP_OKAY;
         if (is_coef(st_ff.awaddr)) begin
            nxt_st.coef[st_ff.awaddr[6:2]] = st_ff.wdata[`COEF_W-1:0];
         end else if (st_ff.awaddr == `CTRL_ADDR) begin
            nxt_st.en    = st_ff.wdata[`CTRL_EN_BIT];
            nxt_st.scale = st_ff.wdata[`CTRL_SCALE_BIT];
         end else if (st_ff.awaddr == `THR_ADDR) begin
            nxt_st.thr = st_ff.wdata[15:0];
         end else if (st_ff.awaddr != `STATUS_ADDR) begin
            nxt_st.bresp = RESP_SLVERR;
         end
      end
      if (st_ff.bvalid && s_axi_bready) begin
         nxt_st.bvalid  = 1'b0;
         nxt_st.aw_got  = 1'b0;
         nxt_st.w_got   = 1'b0;
         nxt_st.awready = 1'b1;
         nxt_st.wready  = 1'b1;
      end
      // ----------------------------------------
      // axi read
      // ----------------------------------------
      if (s_axi_arvalid && st_ff.arready) begin
         nxt_st.arready = 1'b0;
         nxt_st.rvalid  = 1'b1;
         nxt_st.rresp   = RESP_OKAY;
         nxt_st.rdata   = '0;
         if (is_coef(s_axi_araddr)) begin
            nxt_st.rdata[`COEF_W-1:0] = st_ff.coef[s_axi_araddr[6:2]];
         end else if (s_axi_araddr == `CTRL_ADDR) begin
            nxt_st.rdata[`CTRL_EN_BIT]    = st_ff.en;
            nxt_st.rdata[`CTRL_SCALE_BIT] = st_ff.scale;
         end else if (s_axi_araddr == `STATUS_ADDR) begin
            nxt_st.rdata[`ANG_W-1:0]       = st_ff.out_ang;
            nxt_st.rdata[`STAT_AWAKE_BIT] = st_ff.awake;
         end else if (s_axi_araddr == `THR_ADDR) begin
            nxt_st.rdata[15:0] = st_ff.thr;
         end else begin
            nxt_st.rresp = RESP_SLVERR;
         end
      end
      if (st_ff.rvalid && s_axi_rready) begin
         nxt_st.rvalid  = 1'b0;
         nxt_st.arready = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st_ff         <= '0;
         st_ff.thr     <= `THR_RST;
         st_ff.awready <= 1'b1;
         st_ff.wready  <= 1'b1;
         st_ff.arready <= 1'b1;
         st_ff.awake   <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence s_step;
      adv && st_ff.s1_v;
   endsequence

   sequence s_take;
      pop;
   endsequence

   a_seg_pick: assert property (@(posedge clk) disable iff (reset)
      s_take |=> st_ff.s1_c0 == $past(st_ff.coef[fifo_data[15:11]]))
      else $error("wrong coefficient picked");

   a_wrap_first: assert property (@(posedge clk) disable iff (reset)
      s_take and (fifo_data[15:11] == 5'h1f) |=> st_ff.s1_c1 == $past(st_ff.coef[0]))
      else $error("last segment does not wrap to first");

   a_break_exact: assert property (@(posedge clk) disable iff (reset)
      s_step and (st_ff.en && !st_ff.scale && st_ff.s1_frac == '0)
      |=> lin_angle == $past(st_ff.s1_ang
                             - angle_t'({{4{st_ff.s1_c0[11]}}, st_ff.s1_c0} <<< 1)))
      else $error("breakpoint output wrong");

   a_scale_wide: assert property (@(posedge clk) disable iff (reset)
      s_step and (st_ff.en && st_ff.scale && st_ff.s1_frac == '0)
      |=> lin_angle == $past(st_ff.s1_ang
                             - angle_t'({{4{st_ff.s1_c0[11]}}, st_ff.s1_c0} <<< 2)))
      else $error("wide scale wrong");

   a_mid_interp: assert property (@(posedge clk) disable iff (reset)
      s_step and (st_ff.en && !st_ff.scale && st_ff.s1_frac == 11'h400)
      |=> lin_angle == $past(st_ff.s1_ang
                             - angle_t'({{4{st_ff.s1_c0[11]}}, st_ff.s1_c0}
                                        + {{4{st_ff.s1_c1[11]}}, st_ff.s1_c1})))
      else $error("midpoint interpolation wrong");

   a_bypass_pass: assert property (@(posedge clk) disable iff (reset)
      s_step and (!st_ff.en) |=> lin_angle == $past(st_ff.s1_ang))
      else $error("bypass altered angle");

   a_same_delay: assert property (@(posedge clk) disable iff (reset)
      s_take ##1 adv[*1] |=> lin_valid)
      else $error("pipeline latency broken");

   a_coef_store: assert property (@(posedge clk) disable iff (reset)
      st_ff.aw_got && st_ff.w_got && !st_ff.bvalid && is_coef(st_ff.awaddr)
      |=> st_ff.coef[$past(st_ff.awaddr[6:2])] == $past(st_ff.wdata[11:0]))
      else $error("coefficient not stored");

   a_raw_track: assert property (@(posedge clk) disable iff (reset)
      s_take |=> st_ff.last_raw == $past(fifo_data))
      else $error("tracker saw corrected angle");

   a_wake_rate: assert property (@(posedge clk) disable iff (reset)
      st_ff.win_cnt >= 32'(WAKE_WIN - 1) && low_power
      |=> awake == ($past(mag) > $past(st_ff.thr)))
      else $error("wake decision wrong");

endmodule // angle_linearizer

// [hw/angle_lin_map.svh]
/*
 * constants of the angle linearizer: register offsets, field positions,
 * reset values and timing counts.
 * assumes a 100 MHz clock and a 16-bit angle word covering one full turn.
 */
//Contract
//- thirty-two coefficients, one per breakpoint every 11.25 degrees from zero.
//- at a breakpoint the output is the angle minus that breakpoint's coefficient.
//- each coefficient is a 12-bit two's-complement value, -2048 to +2047.
//- scale bit 0 gives 22.50 degrees full range, bit 1 gives 45.00.
//- between breakpoints the correction interpolates linearly between both neighbours.
//- latency is the same with correction on or off; off passes angle through.
//- with correction off the coefficient contents never affect the output.
//- low-power rotation tracking uses only the uncorrected angle.
//- low-power wake when angle change rate exceeds threshold; default about 100 RPM (code: 16'h0048 per 1310 us window, about 50 RPM).
`ifndef ANGLE_LIN_MAP_SVH
`define ANGLE_LIN_MAP_SVH

// ----------------------------------------
// geometry
// ----------------------------------------
`define ANG_W        16
`define NUM_COEF     32
`define SEG_W        5
`define FRAC_W       11
`define COEF_W       12
`define FIFO_DEPTH   8

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define COEF_BASE    8'h00
`define COEF_LAST    8'h7c
`define CTRL_ADDR    8'h80
`define STATUS_ADDR  8'h84
`define THR_ADDR     8'h88

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define CTRL_EN_BIT    0
`define CTRL_SCALE_BIT 1
`define STAT_AWAKE_BIT 16
`define CTRL_RST       2'h0
`define COEF_RST       12'h000
`define THR_RST        16'h0048

// ----------------------------------------
// wake window: time in us, cycles at 10 ns
// ----------------------------------------
`define WAKE_WIN_US  1310
`define CLK_NS       10
`define WAKE_WIN_CYC ((`WAKE_WIN_US * 1000) / `CLK_NS)

`endif

// [hw/angle_lin_pkg.sv]
/*
 * types of the angle linearizer.
 * assumes angle_lin_map.svh on the include path.
 */
`include "angle_lin_map.svh"

package angle_lin_pkg;

   typedef logic [`ANG_W-1:0]  angle_t;
   typedef logic [`COEF_W-1:0] coef_t;

   typedef enum logic [1:0] {
      RESP_OKAY   = 2'b00,
      RESP_SLVERR = 2'b10
   } resp_t;

endpackage

// [verification/angle_peer.sv]
/* stream partner of the angle linearizer: raw angle source and corrected angle sink.
   assumes the testbench fills tx_q, drives stall and reads rx_q and lat. */
`timescale 1ns/1ps
module angle_peer
   import angle_lin_pkg::*;
(
   // clock and reset
   input  wire logic   clk,
   input  wire logic   reset,
   // raw angle source
   output logic        angle_valid,
   input  wire logic   angle_ready,
   output angle_t      angle_in,
   // corrected angle sink
   input  wire logic   lin_valid,
   output logic        lin_ready,
   input  wire angle_t lin_angle,
   input  wire logic   stall
);
   angle_t tx_q[$];
   angle_t rx_q[$];
   int     t_q[$];
   int     cyc = 0;
   int     lat = 0;

   // ------------------------------
   // source holds each word until taken, sink records order and latency
   // ------------------------------
   always @(posedge clk) begin
      cyc <= cyc + 1;
      lin_ready <= !stall && !reset;
      if (lin_valid && lin_ready) begin
         rx_q.push_back(lin_angle);
         lat = cyc - t_q.pop_front();
      end
      if (angle_valid && angle_ready) begin
         t_q.push_back(cyc);
         void'(tx_q.pop_front());
      end
      if (tx_q.size() > 0 && !reset) begin
         angle_valid <= 1'b1;
         angle_in <= tx_q[0];
      end else begin
         // released bus shows no stale value
         angle_valid <= 1'b0;
         angle_in <= reset ? 16'h0000 : ~angle_in;
      end
   end
endmodule // angle_peer

// [verification/tb_top.sv]
/* testbench of the angle linearizer: register access over axi4-lite and stream tests.
   assumes angle_peer as stream partner and a 100 MHz clock. */
`timescale 1ns/1ps
`include "angle_lin_map.svh"
module tb_top
   import angle_lin_pkg::*;
;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic        angle_valid, angle_ready, lin_valid, lin_ready, awake;
   logic        low_power = 1'b0;
   logic        stall = 1'b0;
   angle_t      angle_in, lin_angle;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        en = 1'b0, sc = 1'b0;
   int          coef[32];
   int          bad_count = 0, comparisons = 0, h, lat_ref = -1;

   always #5 clk = ~clk;

   angle_linearizer #(.WAKE_WIN(16)) angle_linearizer_i (.*);
   angle_peer angle_peer_i (.*);

   // ------------------------------
   // tasks
   // ------------------------------
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      v = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   task automatic setctrl(input logic e, input logic s);
      en = e;
      sc = s;
      axw(`CTRL_ADDR, {30'h0, s, e}, r);
   endtask

   task automatic wcoef(input int i);
      axw(8'(4 * i), 32'(coef[i]), r);
   endtask

   // expected output: angle minus interpolated, scaled correction
   function automatic angle_t model(input angle_t a);
      int s, f, c0, c1, corr;
      s = a[15:11];
      f = a[10:0];
      c0 = coef[s];
      c1 = coef[(s + 1) % 32];
      corr = (c0 * 2048 + (c1 - c0) * f) >>> (10 - sc);
      if (!en) corr = 0;
      return a - corr[15:0];
   endfunction

   task automatic wait_rx(input int n);
      repeat (200) if (angle_peer_i.rx_q.size() < n) @(posedge clk);
   endtask

   task automatic xfer(input angle_t a);
      angle_peer_i.tx_q.push_back(a);
      wait_rx(1);
      chk("lin_angle", model(a), angle_peer_i.rx_q.pop_front());
      if (lat_ref < 0) lat_ref = angle_peer_i.lat;
      chk("latency", lat_ref, angle_peer_i.lat);
   endtask

   task automatic watch(input int n, output int hi);
      hi = 0;
      repeat (n) begin
         @(posedge clk);
         if (awake === 1'b1) hi++;
      end
   endtask

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // ------------------------------
   // tests
   // ------------------------------
   initial begin
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      axr(`CTRL_ADDR, d, r);
      chk("ctrl reset", 32'h0, d);
      axr(`THR_ADDR, d, r);
      chk("thr reset", 32'h48, d);
      axr(8'hfc, d, r);
      chk("rresp unmapped", RESP_SLVERR, r);
      axw(8'hfc, 32'h1, r);
      chk("bresp unmapped", RESP_SLVERR, r);
      axw(8'h14, 32'hfffff800, r);
      axr(8'h14, d, r);
      chk("coef width", 32'h800, d);
      axr(`COEF_LAST, d, r);
      chk("coef last reset", 32'h0, d);
      axw(`THR_ADDR, 32'h1234, r);
      axr(`THR_ADDR, d, r);
      chk("thr write", 32'h1234, d);
      axw(`THR_ADDR, 32'(`THR_RST), r);
      axw(`STATUS_ADDR, 32'h1, r);
      chk("bresp status", RESP_OKAY, r);
      $display("test registers done");
      for (int i = 0; i < 32; i++) begin
         coef[i] = 1000 - 61 * i;
         wcoef(i);
      end
      setctrl(1'b0, 1'b1);
      for (int i = 0; i < 4; i++) xfer(16'h1234 + 16'(i * 'h3c51));
      $display("test bypass done");
      setctrl(1'b1, 1'b0);
      for (int k = 0; k < 32; k++) begin
         xfer({5'(k), 11'h000});
         xfer({5'(k), 11'h5a3});
      end
      coef[0] = -2048;
      coef[1] = 2047;
      wcoef(0);
      wcoef(1);
      for (int s = 0; s < 2; s++) begin
         setctrl(1'b1, 1'(s));
         xfer(16'h0000);
         xfer(16'h0800);
         xfer(16'h0400);
      end
      $display("test correction done");
      stall <= 1'b1;
      for (int i = 0; i < 12; i++) angle_peer_i.tx_q.push_back(16'(i * 'h1111));
      repeat (30) @(posedge clk);
      chk("angle_ready full", 1'b0, angle_ready);
      stall <= 1'b0;
      wait_rx(12);
      for (int i = 0; i < 12; i++) begin
         d = 32'(model(16'(i * 'h1111)));
         chk("stalled order", d, angle_peer_i.rx_q.pop_front());
      end
      $display("test backpressure done");
      coef[0] = 2047;
      coef[1] = -2048;
      wcoef(0);
      wcoef(1);
      setctrl(1'b1, 1'b1);
      low_power <= 1'b1;
      xfer(16'h0000);
      watch(40, h);
      xfer(16'h0040);
      watch(40, h);
      chk("awake small raw step", 0, h);
      xfer(16'h0100);
      watch(40, h);
      chk("awake large raw step", 1, h > 0);
      axr(`STATUS_ADDR, d, r);
      chk("status angle", 32'(model(16'h0100)), {16'h0, d[15:0]});
      $display("test wake done");
      stop_test();
   end

   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      stop_test();
   end
endmodule // tb_top
